// ===== flash_cmd_defines.svh
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH

// opcodes handled by this block
`define OP_SEC_READ 8'h48
`define OP_LOCK_ONE 8'h36
`define OP_UNLOCK_ONE 8'h39
`define OP_READ_LOCK 8'h3D
`define OP_LOCK_ALL 8'h7E
`define OP_UNLOCK_ALL 8'h98
`define OP_RESET_ENABLE 8'h66
`define OP_RESET 8'h99
`define OP_PARAM_READ 8'h5A

// array, lock and status layout
`define ERASED_BYTE 8'hFF
`define STATUS_RESET 22'h00_0000
`define LOCK_RESET_VALUE 1'b1
`define BLOCK_COUNT 1024
`define BLOCK_LSB 16
`define BLOCK_MSB 25
`define SEC_ADDR_MSB 11
`define SEC_LAST_BYTE 12'hFFF
`define SEC_FIRST_BYTE 12'h000
`define PARAM_SIGNATURE 32'h1357_9BDF // arbitrary table signature value
`define XIP_EXIT_EDGES 6'h08

// synchroniser reset: chip select idles high
`define PIN_RESET 6'h01

// timing
`define CLK_MHZ 20
`define RST_TIME_US 40
`define RST_E_TIME_MS 25
`define RST_CYCLES (`RST_TIME_US * `CLK_MHZ)
`define RST_E_CYCLES (`RST_E_TIME_MS * 1000 * `CLK_MHZ)

`endif

// ===== flash_cmd_pkg.sv
package flash_cmd_pkg;

  // command frame phases
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_OPC    = 8'h02,
    ST_ADDR   = 8'h04,
    ST_DUMMY  = 8'h08,
    ST_DATA   = 8'h10,
    ST_DONE   = 8'h20,
    ST_IGNORE = 8'h40,
    ST_XIP    = 8'h80
  } state_type;

  // volatile settings cleared by a software reset
  typedef struct packed {
    logic addr4;
    logic four_line_command_mode;
    logic write_enable_latch;
    logic [1:0] suspend_flags;
    logic deep_power_down;
    logic [7:0] read_param_bits;
    logic [7:0] continuous_read_mode_bits;
  } vol_type;

  // whole state of the command core
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] filt;
    state_type st;
    logic [5:0] cnt;
    logic [31:0] sh;
    logic [7:0] op;
    logic [31:0] addr;
    logic uniform;
    logic rst_en;
    logic [18:0] busy;
    vol_type vol;
    logic [1023:0] locks;
    logic [7:0] osh;
    logic [2:0] orem;
    logic [3:0] io_out;
    logic [3:0] io_oe_n;
    logic abort;
    logic prot;
  } core_type;

  // two-entry byte buffer state
  typedef struct packed {
    logic [1:0][7:0] mem;
    logic [1:0] count;
    logic rd;
  } buf_type;

endpackage

// ===== byte_stream_if.sv
`timescale 1ns/1ps
interface byte_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== byte_buffer.sv
`timescale 1ns/1ps
module byte_buffer import flash_cmd_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  byte_stream_if.snk in_s,
  byte_stream_if.src out_s
);
  buf_type q_reg;
  buf_type q_next;
  logic push;
  logic pop;

  // handshakes straight from the fill level
  assign in_s.ready = (q_reg.count != 2'h2);
  assign out_s.valid = (q_reg.count != 2'h0);
  assign out_s.data = q_reg.mem[q_reg.rd];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.ready && out_s.valid;

  // write behind the oldest entry, read from the oldest
  always_comb begin
    q_next = q_reg;
    if (flush_i) begin
      q_next.count = 2'h0;
      q_next.rd = 1'b0;
    end else begin
      if (push) begin
        q_next.mem[q_reg.rd ^ q_reg.count[0]] = in_s.data;
      end
      if (pop) begin
        q_next.rd = ~q_reg.rd;
      end
      q_next.count = q_reg.count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_BUF_NO_OVERRUN: assert property (q_reg.count != 2'h3)
    else $error("byte buffer fill level out of range");
endmodule // byte_buffer

// ===== flash_cmd_core.sv
`timescale 1ns/1ps
`include "flash_cmd_defines.svh"
module flash_cmd_core import flash_cmd_pkg::*; #(
  parameter int unsigned RST_E_CYCLES = `RST_E_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_n_o,
  input wire logic lock_scheme_select_i,
  input wire logic [4:0] protect_range_bits_i,
  input wire logic [9:0] query_block_i,
  output logic block_protected_o,
  input wire logic erase_active_i,
  input wire logic vol_load_i,
  input wire vol_type vol_i,
  output vol_type vol_o,
  output logic busy_o,
  output logic abort_o
);
  core_type r_reg;
  core_type r_next;
  logic [5:0] filt_nx;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic [3:0] io_now;
  logic [5:0] opc_last;
  logic [5:0] addr_last;
  logic [5:0] dummy_last;
  logic [31:0] shin;
  logic [9:0] lock_blk;
  logic [11:0] sec_low;
  logic push_valid;
  logic [7:0] push_data;
  logic push_fire;
  logic pop_take;
  logic accept;
  logic lock_q;
  logic [10:0] top_cnt;
  logic bp_hit;
  logic [7:0] obyte;
  localparam logic [31:0] SIG_WORD = `PARAM_SIGNATURE; // a literal cannot be part-selected

  byte_stream_if push_s ();
  byte_stream_if pop_s ();

  // output stage buffer, emptied at every frame end
  byte_buffer u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(cs_rise),
    .in_s(push_s),
    .out_s(pop_s)
  );

  // a pin rise counts once stages two and three agree; a fall counts as soon as they differ
  assign filt_nx = (r_reg.filt & (r_reg.s2 ^~ r_reg.s3)) | (r_reg.s3 & (r_reg.s2 ^~ r_reg.s3));
  assign cs_fall = r_reg.filt[0] & ~filt_nx[0];
  assign cs_rise = ~r_reg.filt[0] & filt_nx[0];
  assign sck_rise = ~r_reg.filt[1] & filt_nx[1] & ~filt_nx[0];
  assign sck_fall = r_reg.filt[1] & ~filt_nx[1] & ~filt_nx[0];
  assign io_now = filt_nx[5:2];

  // phase lengths in clock edges
  assign opc_last = r_reg.vol.four_line_command_mode ? 6'h01 : 6'h07;
  assign addr_last = r_reg.vol.four_line_command_mode ? (r_reg.vol.addr4 ? 6'h07 : 6'h05)
                                                      : (r_reg.vol.addr4 ? 6'h1F : 6'h17);
  assign dummy_last = r_reg.vol.four_line_command_mode ? 6'h01 : 6'h07;
  assign shin = r_reg.vol.four_line_command_mode ? {r_reg.sh[27:0], io_now} : {r_reg.sh[30:0], io_now[0]};

  assign lock_blk = r_reg.addr[`BLOCK_MSB:`BLOCK_LSB];
  assign sec_low = r_reg.addr[`SEC_ADDR_MSB:0];
  assign lock_q = r_reg.locks[query_block_i];

  // range protection covers the top 2^(n-1) blocks
  always_comb begin
    if (protect_range_bits_i == 5'h00) begin
      top_cnt = 11'h000;
    end else if (protect_range_bits_i >= 5'h0B) begin
      top_cnt = 11'h400;
    end else begin
      top_cnt = 11'h001 << (protect_range_bits_i - 5'h01);
    end
    bp_hit = ({1'b0, query_block_i} >= (11'h400 - top_cnt)) && (top_cnt != 11'h000);
  end

  // byte producer feeding the buffer
  always_comb begin
    push_valid = (r_reg.st == ST_DUMMY) || (r_reg.st == ST_DATA);
    unique case (r_reg.op)
      `OP_READ_LOCK: push_data = {7'h00, r_reg.locks[lock_blk]};
      `OP_PARAM_READ: push_data = (r_reg.addr[7:2] == 6'h00) ?
                                  SIG_WORD[{r_reg.addr[1:0], 3'h0} +: 8] : `ERASED_BYTE;
      default: push_data = `ERASED_BYTE;
    endcase
  end
  assign push_s.valid = push_valid;
  assign push_s.data = push_data;
  assign push_fire = push_valid && push_s.ready;
  assign pop_s.ready = pop_take;
  assign accept = cs_rise && (r_reg.st == ST_DONE) && (r_reg.op == `OP_RESET) && r_reg.rst_en;
  assign pop_take = sck_fall && (r_reg.st == ST_DATA) && (r_reg.orem == 3'h0) && pop_s.valid;
  assign obyte = pop_s.valid ? pop_s.data : `ERASED_BYTE;

  // next state of the whole core
  always_comb begin
    r_next = r_reg;
    r_next.abort = 1'b0;
    r_next.s1 = {io_i, sclk_i, cs_n_i};
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.filt = filt_nx;
    r_next.prot = lock_scheme_select_i ? bp_hit : lock_q;
    if (r_reg.busy != 19'h0_0000) begin
      r_next.busy = r_reg.busy - 19'h0_0001;
    end
    if (vol_load_i) begin
      r_next.vol = vol_i;
    end
    unique case (r_reg.st)
      ST_IDLE: begin
        if (cs_fall) begin
          r_next.cnt = 6'h00;
          r_next.uniform = 1'b1;
          if (r_reg.busy != 19'h0_0000) begin
            r_next.st = ST_IGNORE;
          end else if (r_reg.vol.continuous_read_mode_bits != 8'h00) begin
            r_next.st = ST_XIP;
          end else begin
            r_next.st = ST_OPC;
          end
        end
      end
      ST_OPC: begin
        if (sck_rise) begin
          r_next.sh = shin;
          r_next.cnt = r_reg.cnt + 6'h01;
          if (r_reg.cnt == opc_last) begin
            r_next.op = shin[7:0];
            r_next.cnt = 6'h00;
            unique case (shin[7:0])
              `OP_SEC_READ, `OP_READ_LOCK, `OP_PARAM_READ, `OP_LOCK_ONE, `OP_UNLOCK_ONE: r_next.st = ST_ADDR;
              `OP_LOCK_ALL, `OP_UNLOCK_ALL, `OP_RESET_ENABLE, `OP_RESET: r_next.st = ST_DONE;
              default: r_next.st = ST_IGNORE;
            endcase
          end
        end
      end
      ST_ADDR: begin
        if (sck_rise) begin
          r_next.sh = shin;
          r_next.cnt = r_reg.cnt + 6'h01;
          if (r_reg.cnt == addr_last) begin
            r_next.addr = r_reg.vol.addr4 ? shin : {8'h00, shin[23:0]};
            r_next.cnt = 6'h00;
            if (r_reg.op == `OP_READ_LOCK) begin
              r_next.st = ST_DATA;
            end else if (r_reg.op == `OP_SEC_READ || r_reg.op == `OP_PARAM_READ) begin
              r_next.st = ST_DUMMY;
            end else begin
              r_next.st = ST_DONE;
            end
          end
        end
      end
      ST_DUMMY: begin
        if (sck_rise) begin
          r_next.cnt = r_reg.cnt + 6'h01;
          if (r_reg.cnt == dummy_last) begin
            r_next.st = ST_DATA;
          end
        end
      end
      ST_DONE: begin
        if (sck_rise) begin
          r_next.st = ST_IGNORE; // extra clocks void a short command
        end
      end
      ST_XIP: begin
        if (sck_rise) begin
          if (r_reg.cnt != 6'h3F) begin
            r_next.cnt = r_reg.cnt + 6'h01;
          end
          r_next.uniform = r_reg.uniform && (io_now == 4'hF || io_now == 4'h0);
        end
      end
      ST_DATA, ST_IGNORE: begin
      end
    endcase
    // address advance after each produced security or parameter byte; lock status reads keep the address
    if (push_fire) begin
      if (r_reg.op == `OP_SEC_READ) begin
        r_next.addr[`SEC_ADDR_MSB:0] = sec_low + 12'h001;
      end else if (r_reg.op == `OP_PARAM_READ) begin
        r_next.addr = r_reg.addr + 32'h0000_0001;
      end
    end
    // serial output on falling edges
    if (sck_fall && r_reg.st == ST_DATA) begin
      r_next.io_oe_n = r_reg.vol.four_line_command_mode ? 4'h0 : 4'hD;
      if (r_reg.orem == 3'h0) begin
        if (r_reg.vol.four_line_command_mode) begin
          r_next.io_out = obyte[7:4];
          r_next.osh = {obyte[3:0], 4'h0};
          r_next.orem = 3'h1;
        end else begin
          r_next.io_out = {2'h0, obyte[7], 1'b0};
          r_next.osh = {obyte[6:0], 1'b0};
          r_next.orem = 3'h7;
        end
      end else begin
        if (r_reg.vol.four_line_command_mode) begin
          r_next.io_out = r_reg.osh[7:4];
          r_next.osh = {r_reg.osh[3:0], 4'h0};
        end else begin
          r_next.io_out = {2'h0, r_reg.osh[7], 1'b0};
          r_next.osh = {r_reg.osh[6:0], 1'b0};
        end
        r_next.orem = r_reg.orem - 3'h1;
      end
    end
    // frame end: execute short commands and release the lines
    if (cs_rise) begin
      r_next.st = ST_IDLE;
      r_next.orem = 3'h0;
      r_next.io_oe_n = 4'hF;
      r_next.rst_en = (r_reg.st == ST_DONE) && (r_reg.op == `OP_RESET_ENABLE);
      if (r_reg.st == ST_DONE) begin
        if (r_reg.op == `OP_LOCK_ONE) begin
          r_next.locks[lock_blk] = 1'b1;
        end else if (r_reg.op == `OP_UNLOCK_ONE) begin
          r_next.locks[lock_blk] = 1'b0;
        end else if (r_reg.op == `OP_LOCK_ALL) begin
          r_next.locks = {`BLOCK_COUNT{1'b1}};
        end else if (r_reg.op == `OP_UNLOCK_ALL) begin
          r_next.locks = {`BLOCK_COUNT{1'b0}};
        end
      end
      if (r_reg.st == ST_XIP && r_reg.cnt == `XIP_EXIT_EDGES && r_reg.uniform) begin
        r_next.vol.continuous_read_mode_bits = 8'h00;
      end
    end
    if (accept) begin
      r_next.vol = `STATUS_RESET;
      r_next.locks = {`BLOCK_COUNT{`LOCK_RESET_VALUE}};
      r_next.abort = 1'b1;
      r_next.busy = erase_active_i ? RST_E_CYCLES[18:0] : 19'(`RST_CYCLES);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.s1 <= `PIN_RESET;
      r_reg.s2 <= `PIN_RESET;
      r_reg.s3 <= `PIN_RESET;
      r_reg.filt <= `PIN_RESET;
      r_reg.st <= ST_IDLE;
      r_reg.locks <= {`BLOCK_COUNT{`LOCK_RESET_VALUE}};
      r_reg.io_oe_n <= 4'hF;
    end else begin
      r_reg <= r_next;
    end
  end

  // registered outputs
  assign io_o = r_reg.io_out;
  assign io_oe_n_o = r_reg.io_oe_n;
  assign block_protected_o = r_reg.prot;
  assign vol_o = r_reg.vol;
  assign busy_o = (r_reg.busy != 19'h0_0000);
  assign abort_o = r_reg.abort;

  // checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_SEC_WRAP: assert property (
    push_fire && r_reg.op == `OP_SEC_READ && sec_low == `SEC_LAST_BYTE |=> sec_low == `SEC_FIRST_BYTE)
    else $error("security address did not wrap");
  AST_SEC_INC: assert property (
    push_fire && r_reg.op == `OP_SEC_READ && sec_low != `SEC_LAST_BYTE |=> sec_low == $past(sec_low) + 12'h001)
    else $error("security address did not advance by one");
  AST_ADDR24: assert property (
    r_reg.st == ST_ADDR && sck_rise && r_reg.cnt == addr_last && !r_reg.vol.addr4 |=> r_reg.addr[31:24] == 8'h00)
    else $error("upper address byte kept in three-byte mode");
  AST_OUT_ON_FALL: assert property ($changed(io_o) |-> $past(sck_fall))
    else $error("output changed without a falling clock edge");
  AST_LOCK_ONE: assert property (
    cs_rise && r_reg.st == ST_DONE && r_reg.op == `OP_LOCK_ONE |=> r_reg.locks[$past(lock_blk)])
    else $error("block lock bit not set");
  AST_UNLOCK_ONE: assert property (
    cs_rise && r_reg.st == ST_DONE && r_reg.op == `OP_UNLOCK_ONE |=> !r_reg.locks[$past(lock_blk)])
    else $error("block lock bit not cleared");
  AST_READ_LOCK: assert property (
    push_fire && r_reg.op == `OP_READ_LOCK |-> push_data == {7'h00, r_reg.locks[lock_blk]})
    else $error("lock status byte wrong");
  AST_GLOBAL_LOCK: assert property (
    cs_rise && r_reg.st == ST_DONE && r_reg.op == `OP_LOCK_ALL && !accept |=> &r_reg.locks)
    else $error("global lock left a block unlocked");
  AST_RESET_CLEARS: assert property (
    accept |=> r_reg.vol == `STATUS_RESET && abort_o ##1 !abort_o)
    else $error("reset did not restore volatile defaults");
  AST_RESET_PAIR: assert property (
    abort_o |-> $past(r_reg.rst_en, 2))
    else $error("reset taken without an enable frame");
  AST_REFUSE_BUSY: assert property (
    r_reg.st == ST_IDLE && cs_fall && busy_o |=> r_reg.st == ST_IGNORE)
    else $error("command decoded during reset recovery");
  AST_RECOVERY_LEN: assert property (
    accept && !erase_active_i |=> r_reg.busy == 19'(`RST_CYCLES))
    else $error("recovery count wrong");
  AST_XIP_EXIT: assert property (
    cs_rise && r_reg.st == ST_XIP && r_reg.cnt == `XIP_EXIT_EDGES && r_reg.uniform && !vol_load_i
    |=> r_reg.vol.continuous_read_mode_bits == 8'h00)
    else $error("uniform clocks did not leave continuous read");
  AST_SCHEME_LOCK: assert property (!lock_scheme_select_i |=> block_protected_o == $past(lock_q))
    else $error("block lock not applied");
  AST_SCHEME_RANGE: assert property (lock_scheme_select_i |=> block_protected_o == $past(bp_hit))
    else $error("range protection not applied");
  AST_ERASED: assert property (push_fire && r_reg.op == `OP_SEC_READ |-> push_data == `ERASED_BYTE)
    else $error("erased byte not all ones");

  COV_SEC_READ: cover property (pop_take && r_reg.op == `OP_SEC_READ);
  COV_RESET: cover property (accept);
  COV_GLOBAL_UNLOCK: cover property (cs_rise && r_reg.st == ST_DONE && r_reg.op == `OP_UNLOCK_ALL);
  COV_PARAM: cover property (pop_take && r_reg.op == `OP_PARAM_READ);
endmodule // flash_cmd_core

// ===== spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk_i,
  input wire logic [3:0] dev_io_i,
  input wire logic [3:0] dev_oe_n_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] io_o
);
  logic [3:0] drv;
  logic [3:0] last_oe;
  logic [31:0] junk;
  int seed = 74;
  // wire level: the device wins on lines it drives, else the host value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_o[i] = dev_oe_n_i[i] ? drv[i] : dev_io_i[i];
    end
  end
  // idle bus: deselected, clock parked low between frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    drv = 4'h0;
  end
  // one frame; mode 0 single line, 1 four lines, 2 all lines equal
  task automatic xfer(input logic [63:0] b, input int nb, input int nr, input int m, output logic [31:0] rd);
    int step;
    step = (m == 1) ? 4 : 1;
    rd = '0;
    cs_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    for (int i = 0; i < nb + nr; i += step) begin
      junk = $random(seed);
      if (i >= nb) begin
        drv = ~drv; // released lines toggle so stale values never pass
      end else if (m == 1) begin
        drv = b[63 - i -: 4];
      end else if (m == 2) begin
        drv = {4{b[63 - i]}};
      end else begin
        drv = {junk[2:0], b[63 - i]};
      end
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      // read data sampled just before the falling edge that replaces it
      if (i >= nb) begin
        rd = (m == 1) ? {rd[27:0], io_o} : {rd[30:0], io_o[1]};
        last_oe = dev_oe_n_i;
      end
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    drv = ~drv;
    repeat (10) @(negedge clk_i);
  endtask
endmodule // spi_host_model

// ===== tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin $display("MISMATCH %s exp %0h got %0h", n, e, g); n_errors++; end end
module tb import flash_cmd_pkg::*;;
  logic clk_i, rst_i, cs_n_i, sclk_i, lock_scheme_select_i, block_protected_o;
  logic erase_active_i, vol_load_i, busy_o, abort_o;
  logic [3:0] io_i, io_o, io_oe_n_o;
  logic [4:0] protect_range_bits_i;
  logic [9:0] query_block_i;
  logic [31:0] rd;
  vol_type vol_i, vol_o;
  int n_errors, check_count, busy_len, n_abort, blk;
  int seed = 74;
  flash_cmd_core #(.RST_E_CYCLES(2000)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
    .io_i(io_i), .io_o(io_o), .io_oe_n_o(io_oe_n_o), .lock_scheme_select_i(lock_scheme_select_i),
    .protect_range_bits_i(protect_range_bits_i), .query_block_i(query_block_i),
    .block_protected_o(block_protected_o), .erase_active_i(erase_active_i), .vol_load_i(vol_load_i),
    .vol_i(vol_i), .vol_o(vol_o), .busy_o(busy_o), .abort_o(abort_o));
  spi_host_model i_host (.clk_i(clk_i), .dev_io_i(io_o), .dev_oe_n_i(io_oe_n_o), .cs_n_o(cs_n_i),
    .sclk_o(sclk_i), .io_o(io_i));
  // 20 MHz clock
  always #25 clk_i = ~clk_i;
  // count recovery cycles and abort pulses, sampled away from the launching edge
  always @(negedge clk_i) begin
    if (busy_o === 1'b1) busy_len++;
    if (abort_o === 1'b1) n_abort++;
  end
  // expected protection under the range scheme
  function automatic logic prot_exp(input int bp, input int k);
    if (bp == 0) return 1'b0;
    if (bp >= 11) return 1'b1;
    return k >= 1024 - (1 << (bp - 1));
  endfunction
  task automatic xf(input logic [63:0] b, input int nb, input int nr, input int m);
    i_host.xfer(b, nb, nr, m, rd);
  endtask
  task automatic pulse();
    vol_load_i = 1'b1;
    @(negedge clk_i);
    vol_load_i = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic chk_blk(input int k, input logic e);
    query_block_i = 10'(k);
    repeat (2) @(negedge clk_i);
    `CHK("block_protected_o", e, block_protected_o)
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // bounded wait for the end of reset recovery
  task automatic wait_idle();
    for (int k = 0; k < 3000 && busy_o !== 1'b0; k++) @(negedge clk_i);
    if (busy_o !== 1'b0) begin
      n_errors++;
      close_out();
    end
  endtask
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    lock_scheme_select_i = 1'b0;
    protect_range_bits_i = 5'h00;
    query_block_i = 10'h000;
    erase_active_i = 1'b0;
    vol_load_i = 1'b0;
    vol_i = '0;
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (6) @(negedge clk_i);
    // power-up state
    `CHK("vol_o", 22'h00_0000, vol_o)
    `CHK("io_oe_n_o", 4'hF, io_oe_n_o)
    chk_blk(7, 1'b1);
    $display("test power_up done");
    // security register and parameter reads
    xf({8'h48, 24'h00_0FFE, 8'h00, 24'h00_0000}, 40, 32, 0);
    `CHK("secreg_wrap", 32'hFFFF_FFFF, rd)
    `CHK("io_oe_n_o", 4'hD, i_host.last_oe)
    vol_i.addr4 = 1'b1;
    pulse();
    xf({8'h48, 32'h0000_0FFF, 8'h00, 16'h0000}, 48, 16, 0);
    `CHK("secreg_4byte", 32'h0000_FFFF, rd)
    xf({8'h5A, 32'h0000_0001, 8'h00, 16'h0000}, 48, 32, 0);
    `CHK("param_from_1", 32'h9B57_13FF, rd)
    vol_i.addr4 = 1'b0;
    vol_i.four_line_command_mode = 1'b1;
    pulse();
    xf({8'h5A, 24'h00_0000, 8'h00, 24'h00_0000}, 40, 32, 1);
    `CHK("param_quad", 32'hDF9B_5713, rd)
    `CHK("io_oe_n_o", 4'h0, i_host.last_oe)
    vol_i = '0;
    pulse();
    $display("test reads done");
    // block locks
    blk = {$random(seed)} % 255;
    xf({8'h98, 56'h0}, 8, 0, 0);
    chk_blk(blk, 1'b0);
    xf({8'h36, 8'(blk), 48'h0}, 32, 0, 0);
    chk_blk(blk, 1'b1);
    chk_blk(blk + 1, 1'b0);
    xf({8'h3D, 8'(blk), 48'h0}, 32, 8, 0);
    `CHK("lock_read", 32'h0000_0001, rd)
    xf({8'h3D, 8'(blk + 1), 48'h0}, 32, 8, 0);
    `CHK("lock_read", 32'h0000_0000, rd)
    xf({8'h39, 8'(blk), 48'h0}, 32, 0, 0);
    chk_blk(blk, 1'b0);
    xf({8'h7E, 56'h0}, 8, 0, 0);
    chk_blk(blk + 1, 1'b1);
    lock_scheme_select_i = 1'b1;
    for (int b = 0; b < 12; b++) begin
      protect_range_bits_i = 5'(b);
      chk_blk(1023, prot_exp(b, 1023));
      chk_blk(1016, prot_exp(b, 1016));
    end
    lock_scheme_select_i = 1'b0;
    xf({8'h98, 56'h0}, 8, 0, 0);
    chk_blk(1016, 1'b0);
    $display("test locks done");
    // software reset
    vol_i = vol_type'(22'($random(seed)));
    vol_i.addr4 = 1'b0;
    vol_i.four_line_command_mode = 1'b0;
    vol_i.deep_power_down = 1'b0;
    vol_i.continuous_read_mode_bits = 8'h00;
    vol_i.write_enable_latch = 1'b1;
    pulse();
    n_abort = 0;
    xf({8'h66, 56'h0}, 8, 0, 0);
    xf({8'h7E, 56'h0}, 8, 0, 0);
    xf({8'h99, 56'h0}, 8, 0, 0);
    `CHK("abort_count", 0, n_abort)
    `CHK("vol_o", vol_i, vol_o)
    xf({8'h98, 56'h0}, 8, 0, 0);
    `CHK("busy_o", 1'b0, busy_o)
    busy_len = 0;
    xf({8'h66, 56'h0}, 8, 0, 0);
    xf({8'h99, 56'h0}, 8, 0, 0);
    `CHK("abort_count", 1, n_abort)
    `CHK("vol_o", 22'h00_0000, vol_o)
    xf({8'h98, 56'h0}, 8, 0, 0);
    wait_idle();
    chk_blk(blk, 1'b1);
    `CHK("busy_len", 800, busy_len)
    vol_i = '0;
    vol_i.four_line_command_mode = 1'b1;
    pulse();
    erase_active_i = 1'b1;
    busy_len = 0;
    xf({8'h66, 56'h0}, 8, 0, 1);
    xf({8'h99, 56'h0}, 8, 0, 1);
    wait_idle();
    erase_active_i = 1'b0;
    `CHK("busy_len", 2000, busy_len)
    `CHK("vol_o", 22'h00_0000, vol_o)
    $display("test reset done");
    // continuous read mode exit
    vol_i = '0;
    vol_i.continuous_read_mode_bits = 8'hA5;
    pulse();
    xf({8'h98, 56'h0}, 8, 0, 0);
    chk_blk(blk, 1'b1);
    xf(64'h0, 8, 0, 2);
    `CHK("vol_o", 22'h00_0000, vol_o)
    xf({8'h98, 56'h0}, 8, 0, 0);
    chk_blk(blk, 1'b0);
    $display("test xip_exit done");
    close_out();
  end
endmodule // tb
